/* File: dv/pscl_asserts.sv */
// Port-level checks for the strap sampler
module pscl_asserts
  import pscl_pkg::*;
(
  // Clock and reset
  input wire logic                    clk_i,
  input wire logic                    rst_n_i,
  // Pins and configuration
  input wire logic [9:0]              strap_pin_o,
  input wire logic [9:0]              strap_pin_oe_o,
  input wire logic [9:0]              strap_pull_en_o,
  input wire logic [9:0]              strap_pull_up_o,
  input wire logic [9:0]              func_out_i,
  input wire logic [4:0]              mgmt_addr_o,
  input wire pscl_pkg::pscl_if_mode_t if_mode_o,
  input wire logic [2:0]              if_mode_raw_o,
  input wire logic                    cfg_valid_o,
  // Bus handshake
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_ack_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_addr_top_zero: assert property (mgmt_addr_o[4:3] == 2'b00)
    else $error("address top bits set");
  a_pins_drive_run: assert property (cfg_valid_o |-> strap_pin_oe_o == 10'h3_FF
    && strap_pin_o == func_out_i) else $error("pins not driven in run");
  a_pulls_in_reset: assert property (!cfg_valid_o |-> strap_pull_en_o == 10'h3_FF
    && strap_pin_oe_o == 10'h0_00) else $error("pins not pulled inputs");
  a_pull_dir_ok: assert property (strap_pull_up_o == 10'h3_81)
    else $error("pull direction wrong");
  a_valid_holds: assert property (cfg_valid_o |=> cfg_valid_o)
    else $error("config valid dropped");
  a_valid_soon: assert property ($rose(rst_n_i) |-> ##[1:3] cfg_valid_o)
    else $error("config not valid after reset");
  a_cfg_frozen: assert property (cfg_valid_o && $past(cfg_valid_o) |->
    $stable(mgmt_addr_o) && $stable(if_mode_raw_o)) else $error("latched straps moved");
  a_mode_decode: assert property (cfg_valid_o |-> if_mode_o ==
    (if_mode_raw_o == 3'h0 ? PSCL_IF_MII : if_mode_raw_o == 3'h1 ? PSCL_IF_RPIN :
    if_mode_raw_o == 3'h4 ? PSCL_IF_MII_PRE : PSCL_IF_RSVD)) else $error("mode decode wrong");
  a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o ##1 !wb_ack_o) else $error("ack timing wrong");
  // Main scenarios reached
  c_bus_run: cover property (cfg_valid_o && wb_ack_o);
  c_rsvd_mode: cover property (cfg_valid_o && if_mode_o == PSCL_IF_RSVD);
  c_addr_seven: cover property (mgmt_addr_o == 5'h0_7);
endmodule

bind pscl_top pscl_asserts u_chk (.clk_i, .rst_n_i, .strap_pin_o, .strap_pin_oe_o,
  .strap_pull_en_o, .strap_pull_up_o, .func_out_i, .mgmt_addr_o, .if_mode_o,
  .if_mode_raw_o, .cfg_valid_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

/* File: dv/pscl_board.sv */
// Board side of the strap pins: external straps, weak pulls and device drive
module pscl_board (
  // Device pad controls
  input  wire logic [9:0] oe_i,
  input  wire logic [9:0] out_i,
  input  wire logic [9:0] pull_en_i,
  input  wire logic [9:0] pull_up_i,
  // Board straps
  input  wire logic [9:0] drv_i,
  input  wire logic [9:0] val_i,
  // Resolved pin level
  output logic      [9:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Device drive wins; a floating pin drifts so stale data never looks valid
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      if (oe_i[i]) pin_o[i] = out_i[i];
      else if (drv_i[i]) pin_o[i] = val_i[i];
      else if (pull_en_i[i]) pin_o[i] = pull_up_i[i];
      else pin_o[i] = ~out_i[i];
    end
  end
endmodule

/* File: dv/test_phy_strap_config_latch.sv */
// Bench: board straps, bus master and reference model of the strap sampler
module test_phy_strap_config_latch
  import pscl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_n_i = 0, cfg_valid_o, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [9:0] strap_pin_i, strap_pin_o, strap_pin_oe_o, strap_pull_en_o, strap_pull_up_o;
  logic [9:0] func_out_i = 0, bval = 0, bdrv = 0;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd, st = 32'h2362;
  logic [4:0] mgmt_addr_o;
  logic [2:0] if_mode_raw_o;
  pscl_if_mode_t if_mode_o;
  int n_errors = 0, checks_done = 0, s, m, w;
  // Free-running system clock
  always #5 clk_i = ~clk_i;
  pscl_top dut (.clk_i, .rst_n_i, .strap_pin_i, .strap_pin_o, .strap_pin_oe_o,
    .strap_pull_en_o, .strap_pull_up_o, .func_out_i, .mgmt_addr_o, .if_mode_o,
    .if_mode_raw_o, .cfg_valid_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
  pscl_board brd (.oe_i(strap_pin_oe_o), .out_i(strap_pin_o), .pull_en_i(strap_pull_en_o),
    .pull_up_i(strap_pull_up_o), .drv_i(bdrv), .val_i(bval), .pin_o(strap_pin_i));
  function automatic logic [31:0] xs();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic cycle: hold until ack is seen high at a rising edge, then release
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) n_errors++;
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic finish_test();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, far beyond eight reset rounds
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    finish_test();
  end
  // Round 0 leaves pins to the weak pulls; rounds 1..7 strap every other mode code
  initial begin
    for (int i = 0; i < 8; i++) begin
      s = (i == 0) ? 'h381 : (xs() & 'h3C7) | (i << 3);
      m = (s >> 3) & 7;
      bdrv <= (i == 0) ? '0 : '1;
      bval <= s[9:0];
      rst_n_i <= 0;
      repeat (16) @(posedge clk_i);
      chk(strap_pull_en_o, 'h3FF);
      chk(strap_pin_oe_o, 0);
      chk(strap_pull_up_o, 'h381);
      chk(strap_pin_i, s & 'h3FF);
      rst_n_i <= 1;
      repeat (3) @(posedge clk_i);
      func_out_i <= 10'(xs());
      repeat (4) @(posedge clk_i);
      chk(strap_pin_oe_o, 'h3FF);
      chk(strap_pin_o, func_out_i);
      chk(strap_pull_en_o, 0);
      chk(mgmt_addr_o, s & 7);
      chk(if_mode_raw_o, m);
      chk(if_mode_o, m == 0 ? 0 : m == 1 ? 1 : m == 4 ? 2 : 3);
      chk(cfg_valid_o, 1);
      bus(0, 8'h7C, 0);
      chk(rd, s);
      bus(0, 8'h00, 0);
      chk(rd, (s >> 7 & 1) << 13 | (s >> 9 & 1) << 12 | (s >> 6 & 1) << 10 | (~s >> 8 & 1) << 8);
      chk(rd[13], s >> 7 & 1);
      chk(rd[8], ~s >> 8 & 1);
      chk(rd[12], s >> 9 & 1);
      bus(0, 8'h10, 0);
      chk(rd, 'h61 | (s >> 7 & 1) * 'h180);
      w = xs() & 'h3500;
      bus(1, 8'h00, w);
      bus(1, 8'h7C, ~s);
      bus(0, 8'h00, 0);
      chk(rd, w);
      bus(0, 8'h7C, 0);
      chk(rd, s);
      bus(0, 8'h40, 0);
      chk(rd, 0);
      // Low-lane-only write to the advertisement register keeps the high lane
      w = xs() & 'hFFFF;
      wb_sel_i <= 4'h1;
      bus(1, 8'h10, w);
      wb_sel_i <= 4'hF;
      bus(0, 8'h10, 0);
      chk(rd, (('h61 | (s >> 7 & 1) * 'h180) & 'hFF00) | (w & 'hFF));
    end
    finish_test();
  end
endmodule

/* File: logic/pscl_strap_sync.sv */
// Two-flop synchroniser bank for the strap pins
module pscl_strap_sync #(
  parameter int W = 10
) (
  // Clock
  input  wire logic         clk_i,
  // Data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  // First stage feeds only the second
  always_comb begin
    nxt_meta = async_i;
    nxt_sync = meta_ff;
  end

  // No reset: the bank keeps tracking the pins while chip reset is held,
  // so the sequencer sees settled strap levels at its first edge
  always_ff @(posedge clk_i) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  assign sync_o = sync_ff;
endmodule

/* File: logic/pscl_top.sv */
// Strap sampler with control/advertisement registers over Wishbone
module pscl_top
  import pscl_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // Strap pins, split into input, output and enable
  input  wire logic [pscl_pkg::STRAP_W-1:0] strap_pin_i,
  output logic      [pscl_pkg::STRAP_W-1:0] strap_pin_o,
  output logic      [pscl_pkg::STRAP_W-1:0] strap_pin_oe_o,
  output logic      [pscl_pkg::STRAP_W-1:0] strap_pull_en_o,
  output logic      [pscl_pkg::STRAP_W-1:0] strap_pull_up_o,
  // Normal pin functions after reset
  input  wire logic [pscl_pkg::STRAP_W-1:0] func_out_i,
  // Decoded configuration
  output logic      [4:0]                   mgmt_addr_o,
  output pscl_pkg::pscl_if_mode_t           if_mode_o,
  output logic      [2:0]                   if_mode_raw_o,
  output logic                              cfg_valid_o,
  // Wishbone classic slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [7:0]                   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o
);
  import pscl_pkg::*;

  typedef enum {
    ST_SAMPLE,
    ST_LOAD,
    ST_RUN
  } pscl_state_t;

  logic [STRAP_W-1:0] strap_sync;
  pscl_state_t        state_ff;
  pscl_state_t        nxt_state;
  logic [STRAP_W-1:0] latch_ff;
  logic [STRAP_W-1:0] nxt_latch;
  logic [15:0]        ctrl_ff;
  logic [15:0]        nxt_ctrl;
  logic [15:0]        adv_ff;
  logic [15:0]        nxt_adv;
  logic [31:0]        rdat_ff;
  logic [31:0]        nxt_rdat;
  logic               ack_ff;
  logic               nxt_ack;
  logic               req;
  logic               wr_ctrl;
  logic               wr_adv;
  logic [15:0]        wmask;
  logic [15:0]        strap_ctrl;
  logic [15:0]        strap_adv;

  // Synchroniser runs through reset so straps are sampled while pins are inputs
  pscl_strap_sync #(
    .W (STRAP_W)
  ) u_sync (
    .clk_i   (clk_i),
    .async_i (strap_pin_i),
    .sync_o  (strap_sync)
  );

  // Control register image built from the latched straps
  always_comb begin
    strap_ctrl = CTRL_RST;
    strap_ctrl[CTRL_ISOLATE] = latch_ff[SB_ISO];
    strap_ctrl[CTRL_SPEED]   = latch_ff[SB_SPEED];
    strap_ctrl[CTRL_DUPLEX]  = ~latch_ff[SB_DUPLEX];    // pull-up means half
    strap_ctrl[CTRL_ANEG]    = latch_ff[SB_ANEG];
  end

  // Advertisement: only 10 Mbps abilities when strapped to 10
  always_comb begin
    strap_adv = ANADV_RST | ADV_SELECTOR;
    strap_adv[ADV_10H]  = 1'b1;
    strap_adv[ADV_10F]  = 1'b1;
    strap_adv[ADV_100H] = latch_ff[SB_SPEED];
    strap_adv[ADV_100F] = latch_ff[SB_SPEED];
  end

  // Sequencer: sample while pins are inputs, then load registers once
  always_comb begin
    nxt_state = state_ff;
    nxt_latch = latch_ff;
    case (state_ff)
      ST_SAMPLE: begin
        // The synchroniser ran through reset, so the pin levels are already settled at the first edge after release
        nxt_latch = strap_sync;
        nxt_state = ST_LOAD;
      end
      ST_LOAD: begin
        nxt_latch = strap_sync;
        nxt_state = ST_RUN;
      end
      ST_RUN: begin
        nxt_latch = latch_ff;
      end
      default: begin
        nxt_state = ST_SAMPLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_SAMPLE;
      latch_ff <= STRAP_PULLUP;
    end else begin
      state_ff <= nxt_state;
      latch_ff <= nxt_latch;
    end
  end

  // Pins stay pulled inputs until the straps are captured
  always_comb begin
    strap_pull_up_o = STRAP_PULLUP;
    if (state_ff == ST_RUN) begin
      strap_pull_en_o = '0;
      strap_pin_oe_o  = '1;
      strap_pin_o     = func_out_i;
    end else begin
      strap_pull_en_o = '1;
      strap_pin_oe_o  = '0;
      strap_pin_o     = '0;
    end
  end

  // Bus decode; single-cycle ack, dropped the cycle after
  assign req     = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr_ctrl = req & wb_we_i & (wb_adr_i == OFS_CTRL);
  assign wr_adv  = req & wb_we_i & (wb_adr_i == OFS_ANADV);
  assign wmask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Registers: straps load them once, software may overwrite later
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_adv  = adv_ff;
    nxt_ack  = req;
    nxt_rdat = rdat_ff;
    if (state_ff == ST_LOAD) begin
      nxt_ctrl = strap_ctrl;
      nxt_adv  = strap_adv;
    end else if (state_ff == ST_RUN) begin
      if (wr_ctrl) begin
        nxt_ctrl = (ctrl_ff & ~wmask) | (wb_dat_i[15:0] & wmask);
      end
      if (wr_adv) begin
        nxt_adv = (adv_ff & ~wmask) | (wb_dat_i[15:0] & wmask);
      end
    end
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        OFS_CTRL:  nxt_rdat = {16'h0_000, ctrl_ff};
        OFS_ANADV: nxt_rdat = {16'h0_000, adv_ff};
        OFS_STRAP: nxt_rdat = {22'h00_0000, latch_ff};
        default:   nxt_rdat = 32'h0000_0000;            // Unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= CTRL_RST;
      adv_ff  <= ANADV_RST;
      rdat_ff <= 32'h0000_0000;
      ack_ff  <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      adv_ff  <= nxt_adv;
      rdat_ff <= nxt_rdat;
      ack_ff  <= nxt_ack;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // Decoded configuration outputs
  assign mgmt_addr_o   = {2'b00,
                          latch_ff[SB_ADDR2], latch_ff[SB_ADDR1],
                          latch_ff[SB_ADDR0]};
  assign if_mode_raw_o = {latch_ff[SB_MODE2], latch_ff[SB_MODE1],
                          latch_ff[SB_MODE0]};
  assign cfg_valid_o   = (state_ff == ST_RUN);

  // Mode decode; reserved codes flagged rather than guessed
  always_comb begin
    case (if_mode_raw_o)
      MODE_MII:     if_mode_o = PSCL_IF_MII;
      MODE_RPIN:    if_mode_o = PSCL_IF_RPIN;
      MODE_MII_PRE: if_mode_o = PSCL_IF_MII_PRE;
      default:      if_mode_o = PSCL_IF_RSVD;
    endcase
  end
endmodule

/* File: shared/pscl_pkg.sv */
// Package: strap layout, register offsets, bit positions and reset values
// Overview of operation
// - Sample all straps in the two cycles after reset release, hold them
// - Address low bits from three address straps
// - Address bits four and three forced zero
// - Capture three-bit interface mode strap field
// - Decode modes: MII, reduced-pin, preamble restore
// - Isolate strap loads control bit ten
// - Speed strap loads control bit thirteen
// - Speed strap sets advertisement speed capability
// - Duplex strap loads control bit eight
// - Autoneg strap loads control bit twelve
// - Pins pulled inputs in reset, outputs after
package pscl_pkg;
  // Strap vector positions
  localparam int STRAP_W        = 10;
  localparam int SB_ADDR0       = 0;
  localparam int SB_ADDR1       = 1;
  localparam int SB_ADDR2       = 2;
  localparam int SB_MODE0       = 3;
  localparam int SB_MODE1       = 4;
  localparam int SB_MODE2       = 5;
  localparam int SB_ISO         = 6;
  localparam int SB_SPEED       = 7;
  localparam int SB_DUPLEX      = 8;
  localparam int SB_ANEG        = 9;
  // Internal pull direction per strap, 1 = pull-up
  localparam logic [STRAP_W-1:0] STRAP_PULLUP = 10'h3_81;
  // Register offsets (byte address on the bus, 4x the register index)
  localparam logic [7:0] OFS_CTRL   = 8'h0_0;
  localparam logic [7:0] OFS_ANADV  = 8'h1_0;
  localparam logic [7:0] OFS_STRAP  = 8'h7_C;
  // Control register bit positions
  localparam int CTRL_DUPLEX   = 8;
  localparam int CTRL_ISOLATE  = 10;
  localparam int CTRL_ANEG     = 12;
  localparam int CTRL_SPEED    = 13;
  // Advertisement: 10 half/full at 5/6, 100 half/full at 7/8, selector at 4:0
  localparam int ADV_10H       = 5;
  localparam int ADV_10F       = 6;
  localparam int ADV_100H      = 7;
  localparam int ADV_100F      = 8;
  localparam logic [15:0] ADV_SELECTOR = 16'h0_001;
  // Reset values before straps are applied
  localparam logic [15:0] CTRL_RST  = 16'h0_000;
  localparam logic [15:0] ANADV_RST = 16'h0_001;
  // Interface mode codes
  localparam logic [2:0] MODE_MII      = 3'h0;
  localparam logic [2:0] MODE_RPIN     = 3'h1;
  localparam logic [2:0] MODE_MII_PRE  = 3'h4;
  typedef enum logic [1:0] {
    PSCL_IF_MII,
    PSCL_IF_RPIN,
    PSCL_IF_MII_PRE,
    PSCL_IF_RSVD
  } pscl_if_mode_t;
endpackage
